// [logic/dic_input_cond.sv]
`timescale 1ns/1ps
`default_nettype none
module dic_input_cond #(
  parameter int TICK_CYCLES = dic_pkg::SAMPLE_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire dic_pkg::dic_axi_req_type axi_req,
  output dic_pkg::dic_axi_rsp_type axi_rsp,
  input wire logic [15:0] pin_pos,
  input wire logic [15:0] pin_neg,
  output logic threshold_24v_sel,
  output logic differential_sel,
  output logic [31:0] input_state_word
);

  dic_pkg::dic_state_type q;
  dic_pkg::dic_state_type d;

  logic tick_now;
  logic [15:0] sampled;
  logic [15:0] forced;
  logic [15:0] level;
  logic [31:0] normal_word;
  wire logic [31:0] routed_word;
  logic [7:0] rd_addr;
  logic [4:0] rd_idx;
  logic [4:0] wr_idx;

  // byte-lane merge for a full 32-bit register
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction

  // one routed state bit from its source code
  function automatic logic route_bit(input logic [7:0] code,
                                     input logic [15:0] src);
    logic [6:0] idx;
    logic v;
    idx = code[6:0];
    v = 1'b0;
    // codes 01 to 10 pick inputs, bit 7 inverts
    if (idx >= 7'(dic_pkg::SRC_FIRST_INPUT) &&
        idx <= 7'(dic_pkg::NUM_INPUTS)) begin
      v = src[4'(idx - 7'h01)];
    end
    return v ^ code[dic_pkg::SRC_INV_BIT];
  endfunction

  // table entry that mimics unforced normal mode for state bit k
  function automatic logic [7:0] mimic_code(input int k,
                                            input logic [31:0] sfe,
                                            input logic [31:0] inv);
    logic [7:0] c;
    int idx;
    c = dic_pkg::SRC_CONST0;
    idx = (k >= dic_pkg::LEVEL_LSB) ? k - dic_pkg::LEVEL_LSB : k;
    if (k >= dic_pkg::LEVEL_LSB ||
        (k < dic_pkg::NUM_SPECIAL && sfe[k])) begin
      c = {inv[idx], 2'b00, 5'(idx + 1)};
    end
    return c;
  endfunction

  always_comb begin
    d = q;
    rd_addr = {axi_req.araddr[7:2], 2'b00};
    rd_idx = 5'(rd_addr[7:2] - 6'h10);
    wr_idx = 5'(q.awaddr[7:2] - 6'h10);

    // pins cross into aclk through two flops each
    d.pos_s1 = pin_pos;
    d.pos_s2 = q.pos_s1;
    d.neg_s1 = pin_neg;
    d.neg_s2 = q.neg_s1;

    // negative pin used only when differential
    sampled = q.pos_s2;
    if (q.diff) begin
      sampled = q.pos_s2 & ~(q.neg_s2 & dic_pkg::DIFF_CAPABLE) |
                (q.pos_s2 & ~dic_pkg::DIFF_CAPABLE);
    end

    tick_now = (q.cnt == dic_pkg::CNT_W'(TICK_CYCLES - 1));
    d.cnt = tick_now ? '0 : q.cnt + 1'b1;

    forced = (q.fen[15:0] & q.fval[15:0]) | (~q.fen[15:0] & sampled);
    level = forced ^ q.inv[15:0];
    normal_word = '0;
    // input 1 level in bit 16
    normal_word[31:16] = level;
    // special bits 0 to 3, home from input 3
    // enable gates bits 0 to 3
    normal_word[dic_pkg::NUM_SPECIAL-1:0] =
      level[dic_pkg::NUM_SPECIAL-1:0] & q.sfe[dic_pkg::NUM_SPECIAL-1:0];

    if (tick_now) begin
      d.raw = sampled;
      d.state = q.rte ? routed_word : normal_word;
    end

    // write address and data may arrive in either order
    if (axi_req.awvalid && q.aw_rdy) begin
      d.aw_rdy = 1'b0;
      d.awaddr = {axi_req.awaddr[7:2], 2'b00};
    end
    if (axi_req.wvalid && q.w_rdy) begin
      d.w_rdy = 1'b0;
      d.wdata = axi_req.wdata;
      d.wstrb = axi_req.wstrb;
    end
    if (!q.aw_rdy && !q.w_rdy && !q.b_vld) begin
      d.b_vld = 1'b1;
      d.bresp = dic_pkg::RESP_OKAY;
      if (q.awaddr == dic_pkg::ADDR_SFE) begin
        d.sfe = merge(q.sfe, q.wdata, q.wstrb);
      end else if (q.awaddr == dic_pkg::ADDR_INV) begin
        d.inv = merge(q.inv, q.wdata, q.wstrb);
      end else if (q.awaddr == dic_pkg::ADDR_FORCE_EN) begin
        d.fen = merge(q.fen, q.wdata, q.wstrb);
      end else if (q.awaddr == dic_pkg::ADDR_FORCE_VAL) begin
        d.fval = merge(q.fval, q.wdata, q.wstrb);
      end else if (q.awaddr == dic_pkg::ADDR_THRESH) begin
        if (q.wstrb[0]) begin
          d.thr = q.wdata[0];
        end
      end else if (q.awaddr == dic_pkg::ADDR_DIFF) begin
        if (q.wstrb[0]) begin
          d.diff = q.wdata[0];
        end
      end else if (q.awaddr == dic_pkg::ADDR_ROUTE_EN) begin
        if (q.wstrb[0]) begin
          d.rte = q.wdata[0];
          if (q.wdata[0] && !q.rte) begin
            for (int k = 0; k < dic_pkg::ROUTE_ENTRIES; k++) begin
              d.tbl[k] = mimic_code(k, q.sfe, q.inv);
            end
          end
        end
      end else if (q.awaddr >= dic_pkg::ADDR_TBL_FIRST &&
                   q.awaddr <= dic_pkg::ADDR_TBL_LAST) begin
        if (q.wstrb[0]) begin
          d.tbl[wr_idx] = q.wdata[7:0];
        end
      end else if (q.awaddr == dic_pkg::ADDR_RAW ||
                   q.awaddr == dic_pkg::ADDR_STATE) begin
        // read-only: write is dropped quietly
        d.bresp = dic_pkg::RESP_OKAY;
      end else begin
        d.bresp = dic_pkg::RESP_SLVERR;
      end
    end
    if (q.b_vld && axi_req.bready) begin
      d.b_vld = 1'b0;
      d.aw_rdy = 1'b1;
      d.w_rdy = 1'b1;
    end

    // read: one cycle from address handshake to rvalid
    if (axi_req.arvalid && q.ar_rdy) begin
      d.ar_rdy = 1'b0;
      d.r_vld = 1'b1;
      d.rresp = dic_pkg::RESP_OKAY;
      d.rdata = dic_pkg::RST_WORD;
      if (rd_addr == dic_pkg::ADDR_SFE) begin
        d.rdata = q.sfe;
      end else if (rd_addr == dic_pkg::ADDR_INV) begin
        d.rdata = q.inv;
      end else if (rd_addr == dic_pkg::ADDR_FORCE_EN) begin
        d.rdata = q.fen;
      end else if (rd_addr == dic_pkg::ADDR_FORCE_VAL) begin
        d.rdata = q.fval;
      end else if (rd_addr == dic_pkg::ADDR_RAW) begin
        d.rdata = {16'h0000, q.raw};
      end else if (rd_addr == dic_pkg::ADDR_THRESH) begin
        d.rdata = {31'h0000_0000, q.thr};
      end else if (rd_addr == dic_pkg::ADDR_DIFF) begin
        d.rdata = {31'h0000_0000, q.diff};
      end else if (rd_addr == dic_pkg::ADDR_ROUTE_EN) begin
        d.rdata = {31'h0000_0000, q.rte};
      end else if (rd_addr == dic_pkg::ADDR_STATE) begin
        d.rdata = q.state;
      end else if (rd_addr >= dic_pkg::ADDR_TBL_FIRST &&
                   rd_addr <= dic_pkg::ADDR_TBL_LAST) begin
        d.rdata = {24'h00_0000, q.tbl[rd_idx]};
      end else begin
        d.rresp = dic_pkg::RESP_SLVERR;
      end
    end
    if (q.r_vld && axi_req.rready) begin
      d.r_vld = 1'b0;
      d.ar_rdy = 1'b1;
    end
  end

  // entry k drives bit k from raw levels
  for (genvar k = 0; k < dic_pkg::ROUTE_ENTRIES; k++) begin : g_route
    assign routed_word[k] = route_bit(q.tbl[k], sampled);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
      q.aw_rdy <= 1'b1;
      q.w_rdy <= 1'b1;
      q.ar_rdy <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign axi_rsp.awready = q.aw_rdy;
  assign axi_rsp.wready = q.w_rdy;
  assign axi_rsp.bvalid = q.b_vld;
  assign axi_rsp.bresp = q.bresp;
  assign axi_rsp.arready = q.ar_rdy;
  assign axi_rsp.rvalid = q.r_vld;
  assign axi_rsp.rdata = q.rdata;
  assign axi_rsp.rresp = q.rresp;
  // one threshold select for all switchable inputs
  assign threshold_24v_sel = q.thr;
  assign differential_sel = q.diff;
  assign input_state_word = q.state;

  property p_state_on_tick;
    @(posedge aclk) disable iff (!aresetn)
      $changed(q.state) |-> $past(tick_now);
  endproperty
  a_state_on_tick: assert property (p_state_on_tick)
    else $error("state word changed off the sample tick");

  property p_level_bit16;
    @(posedge aclk) disable iff (!aresetn)
      tick_now && !q.rte && !q.fen[0] && !q.inv[0]
      |=> q.state[16] == q.raw[0];
  endproperty
  a_level_bit16: assert property (p_level_bit16)
    else $error("bit 16 does not follow input 1");

  property p_sfe_gates_low;
    @(posedge aclk) disable iff (!aresetn)
      tick_now && !q.rte && !q.sfe[0] |=> !q.state[0];
  endproperty
  a_sfe_gates_low: assert property (p_sfe_gates_low)
    else $error("disabled special function still set");

  property p_force_value;
    @(posedge aclk) disable iff (!aresetn)
      tick_now && !q.rte && q.fen[0] && !q.inv[0] && q.sfe[0]
      |=> q.state[16] == $past(q.fval[0]) && q.state[0] == q.state[16];
  endproperty
  a_force_value: assert property (p_force_value)
    else $error("forced level not taken");

  property p_invert;
    @(posedge aclk) disable iff (!aresetn)
      tick_now && !q.rte && !q.fen[1] && q.inv[1]
      |=> q.state[17] == !q.raw[1];
  endproperty
  a_invert: assert property (p_invert)
    else $error("inversion not applied to input 2");

  property p_route_const;
    @(posedge aclk) disable iff (!aresetn)
      tick_now && q.rte && q.tbl[0] == dic_pkg::SRC_CONST1
      |=> q.state[0];
  endproperty
  a_route_const: assert property (p_route_const)
    else $error("routing constant one not applied");

  property p_route_ignores_force;
    @(posedge aclk) disable iff (!aresetn)
      tick_now && q.rte && q.tbl[17] == 8'h02
      |=> q.state[17] == q.raw[1];
  endproperty
  a_route_ignores_force: assert property (p_route_ignores_force)
    else $error("routing mode altered by config words");

  property p_route_seed;
    @(posedge aclk) disable iff (!aresetn)
      $rose(q.rte) |-> q.tbl[16] == {$past(q.inv[0]), 7'h01};
  endproperty
  a_route_seed: assert property (p_route_seed)
    else $error("routing table not seeded on entry");

  property p_upper_special_zero;
    @(posedge aclk) disable iff (!aresetn)
      tick_now && !q.rte |=> q.state[15:4] == 12'h000;
  endproperty
  a_upper_special_zero: assert property (p_upper_special_zero)
    else $error("unassigned special bits set");

  property p_read_latency;
    @(posedge aclk) disable iff (!aresetn)
      axi_req.arvalid && q.ar_rdy |=> q.r_vld ##0 !q.ar_rdy;
  endproperty
  a_read_latency: assert property (p_read_latency)
    else $error("read answer not one cycle after address");

  property p_home_from_in3;
    @(posedge aclk) disable iff (!aresetn)
      tick_now && !q.rte && q.sfe[2] |=> q.state[2] == q.state[18];
  endproperty
  a_home_from_in3: assert property (p_home_from_in3)
    else $error("home bit does not follow input 3");

  property p_special_inverted;
    @(posedge aclk) disable iff (!aresetn)
      tick_now && !q.rte && q.fen[0] && q.inv[0] && q.sfe[0]
      |=> q.state[0] == !$past(q.fval[0]);
  endproperty
  a_special_inverted: assert property (p_special_inverted)
    else $error("inversion not applied to special bit 0");

  property p_bit0_neg_limit;
    @(posedge aclk) disable iff (!aresetn)
      tick_now && !q.rte && q.sfe[0] |=> q.state[0] == q.state[16];
  endproperty
  a_bit0_neg_limit: assert property (p_bit0_neg_limit)
    else $error("bit 0 does not follow input 1");

  property p_route_last_entry;
    @(posedge aclk) disable iff (!aresetn)
      tick_now && q.rte && q.tbl[31] == 8'h01
      |=> q.state[31] == q.raw[0];
  endproperty
  a_route_last_entry: assert property (p_route_last_entry)
    else $error("entry 32 does not drive bit 31");

endmodule // dic_input_cond
`default_nettype wire

// [logic/dic_pkg.sv]
`default_nettype none
package dic_pkg;

  localparam int CLK_MHZ = 200;
  localparam int SAMPLE_PERIOD_MS = 1;
  localparam int SAMPLE_CYCLES = SAMPLE_PERIOD_MS * 1000 * CLK_MHZ;
  localparam int CNT_W = 18;

  localparam int NUM_INPUTS = 16;
  localparam int STATE_W = 32;
  localparam int LEVEL_LSB = 16;
  localparam int NUM_SPECIAL = 4;
  localparam int ROUTE_ENTRIES = 32;
  localparam logic [15:0] DIFF_CAPABLE = 16'h0038;

  localparam logic [7:0] ADDR_SFE = 8'h00;
  localparam logic [7:0] ADDR_INV = 8'h04;
  localparam logic [7:0] ADDR_FORCE_EN = 8'h08;
  localparam logic [7:0] ADDR_FORCE_VAL = 8'h0C;
  localparam logic [7:0] ADDR_RAW = 8'h10;
  localparam logic [7:0] ADDR_THRESH = 8'h14;
  localparam logic [7:0] ADDR_DIFF = 8'h18;
  localparam logic [7:0] ADDR_ROUTE_EN = 8'h1C;
  localparam logic [7:0] ADDR_STATE = 8'h20;
  localparam logic [7:0] ADDR_TBL_FIRST = 8'h40;
  localparam logic [7:0] ADDR_TBL_LAST = 8'hBC;

  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [7:0] SRC_CONST0 = 8'h00;
  localparam logic [7:0] SRC_CONST1 = 8'h80;
  localparam int SRC_INV_BIT = 7;
  localparam logic [4:0] SRC_FIRST_INPUT = 5'h01;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [31:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [31:0] araddr;
    logic arvalid;
    logic rready;
  } dic_axi_req_type;

  typedef struct packed {
    logic awready;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
  } dic_axi_rsp_type;

  typedef struct packed {
    logic [15:0] pos_s1;
    logic [15:0] pos_s2;
    logic [15:0] neg_s1;
    logic [15:0] neg_s2;
    logic [CNT_W-1:0] cnt;
    logic [31:0] sfe;
    logic [31:0] inv;
    logic [31:0] fen;
    logic [31:0] fval;
    logic [15:0] raw;
    logic thr;
    logic diff;
    logic rte;
    logic [31:0] state;
    logic [ROUTE_ENTRIES-1:0][7:0] tbl;
    logic aw_rdy;
    logic w_rdy;
    logic b_vld;
    logic [1:0] bresp;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic ar_rdy;
    logic r_vld;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } dic_state_type;

endpackage
`default_nettype wire

// [bench/dic_pin_model.sv]
`timescale 1ns/1ps
`default_nettype none
module dic_pin_model (
  input wire logic aclk,
  input wire logic diff_on,
  output logic [15:0] pin_pos,
  output logic [15:0] pin_neg
);
  logic [15:0] neg_q;
  logic [15:0] junk_q;
  initial begin
    pin_pos = 16'h0000;
    neg_q = 16'h0000;
    junk_q = 16'h5A5A;
  end
  // ignored negatives churn
  // unused negative pins never hold a level the design could lean on
  always @(posedge aclk) junk_q <= ~junk_q;
  assign pin_neg = diff_on ? ((neg_q & dic_pkg::DIFF_CAPABLE) |
                              (junk_q & ~dic_pkg::DIFF_CAPABLE)) : junk_q;
  // switches move just after an edge, like real contacts seen by the sampler
  task automatic drive(input logic [15:0] p, input logic [15:0] n);
    pin_pos <= p;
    neg_q <= n;
  endtask
endmodule // dic_pin_model
`default_nettype wire

// [bench/digital_input_conditioning_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module digital_input_conditioning_tb;
  localparam int TICKS = 20;
  logic aclk;
  logic aresetn;
  dic_pkg::dic_axi_req_type req;
  dic_pkg::dic_axi_rsp_type rsp;
  logic [15:0] pin_pos;
  logic [15:0] pin_neg;
  logic thr_sel;
  logic diff_sel;
  logic [31:0] state;
  logic [31:0] rd;
  logic [1:0] rs;
  int bad_count;
  int samples_checked;

  dic_input_cond #(.TICK_CYCLES(TICKS)) dut (
    .aclk(aclk), .aresetn(aresetn), .axi_req(req), .axi_rsp(rsp),
    .pin_pos(pin_pos), .pin_neg(pin_neg), .threshold_24v_sel(thr_sel),
    .differential_sel(diff_sel), .input_state_word(state));
  dic_pin_model pins (.aclk(aclk), .diff_on(diff_sel),
    .pin_pos(pin_pos), .pin_neg(pin_neg));

  always #2.5 aclk = ~aclk;

  task automatic chk(input string w, input logic [31:0] s,
                     input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", w, e, s);
    end
  endtask

  task automatic test_done();
    $display("compares %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    req.awaddr <= {24'h000000, a};
    req.wdata <= d;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    while (n < 40) begin
      @(posedge aclk);
      n++;
      if (rsp.bvalid === 1'b1) break;
      if (rsp.awready === 1'b1) req.awvalid <= 1'b0;
      if (rsp.wready === 1'b1) req.wvalid <= 1'b0;
    end
    rs = rsp.bresp;
    chk("write answer", {31'h0, rsp.bvalid}, 32'h1);
  endtask

  task automatic axr(input logic [7:0] a);
    int n;
    n = 0;
    req.araddr <= {24'h000000, a};
    req.arvalid <= 1'b1;
    while (n < 40) begin
      @(posedge aclk);
      n++;
      if (rsp.rvalid === 1'b1) break;
      if (rsp.arready === 1'b1) req.arvalid <= 1'b0;
    end
    rd = rsp.rdata;
    rs = rsp.rresp;
    chk("read answer", {31'h0, rsp.rvalid}, 32'h1);
  endtask

  task automatic rchk(input string w, input logic [7:0] a,
                      input logic [31:0] e);
    axr(a);
    chk(w, rd, e);
    chk(w, {30'h0, rs}, {30'h0, dic_pkg::RESP_OKAY});
  endtask

  // two sync flops plus two full tick periods, with margin
  task automatic settle();
    repeat (2 * TICKS + 4) @(posedge aclk);
  endtask

  task automatic t_reset();
    for (int a = 0; a <= 32; a += 4) rchk("reset reg", 8'(a), 32'h0);
    axr(8'h24);
    chk("unmapped rd", rd, 32'h0);
    chk("unmapped rresp", {30'h0, rs}, {30'h0, dic_pkg::RESP_SLVERR});
    wr(dic_pkg::ADDR_STATE, 32'hFFFF_FFFF);
    chk("ro bresp", {30'h0, rs}, {30'h0, dic_pkg::RESP_OKAY});
    rchk("ro state", dic_pkg::ADDR_STATE, 32'h0);
    $display("test reset done");
  endtask

  task automatic t_normal();
    pins.drive(16'h8005, 16'h0000);
    wr(dic_pkg::ADDR_SFE, 32'h0000_000F);
    settle();
    rchk("plain", dic_pkg::ADDR_STATE, 32'h8005_0005);
    chk("plain port", state, 32'h8005_0005);
    wr(dic_pkg::ADDR_SFE, 32'h0000_0004);
    wr(dic_pkg::ADDR_INV, 32'h0000_0003);
    settle();
    rchk("gated inv", dic_pkg::ADDR_STATE, 32'h8006_0004);
    rchk("raw", dic_pkg::ADDR_RAW, 32'h0000_8005);
    $display("test normal done");
  endtask

  task automatic t_force();
    wr(dic_pkg::ADDR_SFE, 32'h0000_000F);
    wr(dic_pkg::ADDR_FORCE_EN, 32'h0000_0003);
    wr(dic_pkg::ADDR_FORCE_VAL, 32'h0000_0000);
    settle();
    rchk("forced", dic_pkg::ADDR_STATE, 32'h8007_0007);
    rchk("raw forced", dic_pkg::ADDR_RAW, 32'h0000_8005);
    $display("test force done");
  endtask

  task automatic t_diff();
    pins.drive(16'h0038, 16'h0008);
    wr(dic_pkg::ADDR_THRESH, 32'hFFFF_FFFF);
    wr(dic_pkg::ADDR_DIFF, 32'h0000_0001);
    chk("thr port", {31'h0, thr_sel}, 32'h1);
    chk("diff port", {31'h0, diff_sel}, 32'h1);
    rchk("thr reg", dic_pkg::ADDR_THRESH, 32'h1);
    settle();
    rchk("raw diff", dic_pkg::ADDR_RAW, 32'h0000_0030);
    wr(dic_pkg::ADDR_DIFF, 32'h0000_0000);
    wr(dic_pkg::ADDR_THRESH, 32'h0000_0000);
    chk("thr off", {31'h0, thr_sel}, 32'h0);
    settle();
    rchk("raw single", dic_pkg::ADDR_RAW, 32'h0000_0038);
    $display("test diff done");
  endtask

  task automatic t_route();
    pins.drive(16'h8005, 16'h0000);
    wr(dic_pkg::ADDR_FORCE_EN, 32'h0000_0000);
    wr(dic_pkg::ADDR_INV, 32'h0000_8001);
    settle();
    rchk("pre route", dic_pkg::ADDR_STATE, 32'h0004_0004);
    wr(dic_pkg::ADDR_ROUTE_EN, 32'h0000_0001);
    settle();
    rchk("route entry", dic_pkg::ADDR_STATE, 32'h0004_0004);
    wr(dic_pkg::ADDR_INV, 32'h0000_0000);
    wr(dic_pkg::ADDR_FORCE_EN, 32'h0000_FFFF);
    wr(8'h40, 32'h0000_0080);
    wr(8'h44, 32'h0000_0083);
    wr(8'h48, 32'h0000_0000);
    wr(8'h80, 32'h0000_0010);
    wr(8'hBC, 32'h0000_0001);
    rchk("entry 2", 8'h44, 32'h0000_0083);
    settle();
    rchk("routed", dic_pkg::ADDR_STATE, 32'h8005_0001);
    wr(dic_pkg::ADDR_ROUTE_EN, 32'h0000_0000);
    settle();
    rchk("route off", dic_pkg::ADDR_STATE, 32'h0000_0000);
    $display("test route done");
  endtask

  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    req = '0;
    req.bready = 1'b1;
    req.rready = 1'b1;
    req.wstrb = 4'hF;
    bad_count = 0;
    samples_checked = 0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_normal();
    t_force();
    t_diff();
    t_route();
    test_done();
  end

  // whole run is a few hundred cycles; this only cuts a hang
  initial begin
    repeat (20000) @(posedge aclk);
    $display("[ERR] watchdog expected finish seen timeout");
    bad_count++;
    test_done();
  end
endmodule // digital_input_conditioning_tb
`default_nettype wire
